// [design/wdtc_top.sv]
/*
  Watchdog timeout control: APB register slave, time base divider,
  timeout counter, reset or interrupt response and sticky timeout flag.
  Registers: control word, timeout status (write one to clear) and mask.
  Assumes one 250 MHz clock, synchronous inputs, and that a watchdog reset
  request is turned into a system reset outside without touching RST_B.
  The time base divider truncates, so real periods run slightly short.
  APB answers with no wait state; a reserved select code is dropped whole.
  The supply alarm is a level: while it stands the arm bit cannot be set.
*/
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "wdtc_regs.svh"

module wdtc_top #(
  parameter int DIV_CYCLES = `WDTC_CLK_HZ / `WDTC_BASE_HZ,
  parameter int BASE_TICKS = `WDTC_BASE_TICKS,
  parameter int CNT_W = `WDTC_CNT_W
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // system side
  input wire logic SUPPLY_ALARM,
  output logic WDT_IRQ,
  output logic IRQ_PRIO_HIGH,
  output logic WDT_RESET_REQ
);

  localparam int DIV_W = $clog2(DIV_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_CYCLES - 1);
  localparam logic [CNT_W-1:0] BASE_CNT = CNT_W'(BASE_TICKS);
  localparam int N_TIMED = int'(`WDTC_CODE_LAST_TIMED) + 1;

  wdtc_pkg::wdtc_ctrl_t ctrl_r, ctrl_nxt;
  wdtc_pkg::wdtc_lock_t lock_r, lock_nxt;
  logic stat_r, stat_nxt;
  logic mask_r, mask_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic irq_r, irq_nxt;
  logic rst_req_r, rst_req_nxt;
  logic access;
  logic wr;
  logic tick;
  logic expire;
  logic reset_resp;

  function automatic logic code_reserved(input logic [3:0] code);
    code_reserved = code > `WDTC_CODE_IMMEDIATE;
  endfunction : code_reserved

  // BASE_TICKS times 2^code ticks of the time base
  function automatic logic [CNT_W-1:0] period_ticks(input logic [3:0] code);
    period_ticks = BASE_CNT << code[2:0];
  endfunction : period_ticks

  function automatic logic [7:0] ctrl_byte(input wdtc_pkg::wdtc_ctrl_t c,
                                           input logic open);
    logic [7:0] b;
    b = 8'h00;
    b[`WDTC_SEL_HI:`WDTC_SEL_LO] = c.sel;
    b[`WDTC_IRSEL_BIT] = c.irsel;
    b[`WDTC_FLAG_BIT] = c.flag;
    b[`WDTC_ARM_BIT] = c.arm;
    b[`WDTC_UNLOCK_BIT] = open;
    ctrl_byte = b;
  endfunction : ctrl_byte

  // completed write to one register
  function automatic logic hits(input logic w, input logic [7:0] a, input logic [7:0] off);
    hits = w && (a == off);
  endfunction : hits

  // addresses that answer without error
  function automatic logic mapped(input logic [7:0] a);
    mapped = a == `WDTC_OFF_CTRL || a == `WDTC_OFF_IRQ_STAT || a == `WDTC_OFF_IRQ_MASK;
  endfunction : mapped

  // read view of a register as it stands at the setup edge
  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h00000000;
    case (a)
      `WDTC_OFF_CTRL: begin
        w[`WDTC_SEL_HI:`WDTC_UNLOCK_BIT] = ctrl_byte(ctrl_r, lock_r == wdtc_pkg::WDTC_OPEN);
      end
      `WDTC_OFF_IRQ_STAT: begin
        w[`WDTC_IRQ_TIMEOUT_BIT] = stat_r;
      end
      `WDTC_OFF_IRQ_MASK: begin
        w[`WDTC_IRQ_TIMEOUT_BIT] = mask_r;
      end
      default: begin
        w = 32'h00000000;
      end
    endcase
    read_word = w;
  endfunction : read_word

  // decoded bus events, shared by the register groups below
  logic slot_wr;
  logic [CNT_W-1:0] period_last [N_TIMED];
  assign access = PSEL & PENABLE & pready_r;
  assign wr = access & PWRITE;
  assign tick = (div_r == DIV_LAST);
  // only a legal code lands; a reserved one still uses up the slot
  assign slot_wr = (lock_r == wdtc_pkg::WDTC_OPEN) && hits(wr, PADDR, `WDTC_OFF_CTRL) &&
                   !code_reserved(PWDATA[`WDTC_SEL_HI:`WDTC_SEL_LO]);

  // one compare value per timed code, fixed by the parameters
  for (genvar g = 0; g < N_TIMED; g++) begin : g_period
    assign period_last[g] = period_ticks(4'(g)) - 1'b1;
  end

  // bus answer: ready and data prepared in the setup cycle, no wait state
  always_comb begin
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    if (PSEL && !PENABLE) begin
      pready_nxt = 1'b1;
      prdata_nxt = read_word(PADDR);
      pslverr_nxt = !mapped(PADDR);
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // unlock sequence: the transfer right after the unlock closes the slot
  always_comb begin
    lock_nxt = lock_r;
    case (lock_r)
      wdtc_pkg::WDTC_LOCKED: begin
        if (hits(wr, PADDR, `WDTC_OFF_CTRL) && PWDATA[`WDTC_UNLOCK_BIT]) begin
          lock_nxt = wdtc_pkg::WDTC_OPEN;
        end
      end
      wdtc_pkg::WDTC_OPEN: begin
        if (access) begin
          lock_nxt = wdtc_pkg::WDTC_LOCKED;
        end
      end
      default: begin
        lock_nxt = wdtc_pkg::WDTC_LOCKED;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      lock_r <= wdtc_pkg::WDTC_LOCKED;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  // timeout detection; code 8 needs no tick and fires on the first armed clock
  always_comb begin
    expire = 1'b0;
    reset_resp = !ctrl_r.irsel || ctrl_r.sel == `WDTC_CODE_IMMEDIATE;
    if (ctrl_r.arm) begin
      if (ctrl_r.sel == `WDTC_CODE_IMMEDIATE) begin
        expire = 1'b1;
      end else if (tick && ctrl_r.sel <= `WDTC_CODE_LAST_TIMED) begin
        expire = (cnt_r == period_last[ctrl_r.sel[2:0]]);
      end
    end
  end

  // control word, time base and timeout counter
  always_comb begin
    ctrl_nxt = ctrl_r;
    div_nxt = tick ? '0 : div_r + 1'b1;
    cnt_nxt = cnt_r;
    rst_req_nxt = 1'b0;
    if (ctrl_r.arm && tick && !expire && ctrl_r.sel <= `WDTC_CODE_LAST_TIMED) begin
      cnt_nxt = cnt_r + 1'b1;
    end
    if (slot_wr) begin
      ctrl_nxt.sel = PWDATA[`WDTC_SEL_HI:`WDTC_SEL_LO];
      ctrl_nxt.irsel = PWDATA[`WDTC_IRSEL_BIT];
      ctrl_nxt.arm = PWDATA[`WDTC_ARM_BIT];
      if (!PWDATA[`WDTC_FLAG_BIT]) begin
        ctrl_nxt.flag = 1'b0;
      end
      if (PWDATA[`WDTC_ARM_BIT]) begin
        cnt_nxt = '0;
        div_nxt = '0;
      end
    end
    if (SUPPLY_ALARM) begin
      ctrl_nxt.arm = 1'b0;
    end
    // events applied after the software write so a set beats a clear
    if (expire) begin
      ctrl_nxt.flag = 1'b1;
      cnt_nxt = '0;
      if (reset_resp) begin
        rst_req_nxt = 1'b1;
        ctrl_nxt.arm = 1'b0;
      end
    end
  end

  // flag survives a watchdog reset: only RST_B or a control write with the flag bit low clears it
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_r <= wdtc_pkg::wdtc_ctrl_t'(`WDTC_CTRL_RESET >> `WDTC_ARM_BIT);
      div_r <= '0;
      cnt_r <= '0;
      rst_req_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      div_r <= div_nxt;
      cnt_r <= cnt_nxt;
      rst_req_r <= rst_req_nxt;
    end
  end

  // status, mask and interrupt; no global enable anywhere in this path
  always_comb begin
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    if (hits(wr, PADDR, `WDTC_OFF_IRQ_STAT) && PWDATA[`WDTC_IRQ_TIMEOUT_BIT]) begin
      stat_nxt = 1'b0;
    end
    if (hits(wr, PADDR, `WDTC_OFF_IRQ_MASK)) begin
      mask_nxt = PWDATA[`WDTC_IRQ_TIMEOUT_BIT];
    end
    if (expire && !reset_resp) begin
      stat_nxt = 1'b1;
    end
    irq_nxt = stat_r & mask_r;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      stat_r <= `WDTC_IRQ_STAT_RESET;
      mask_r <= `WDTC_IRQ_MASK_RESET;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  // priority is hard wired, so a flop that only ever loads one
  logic prio_r;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      prio_r <= 1'b1;
    end else begin
      prio_r <= 1'b1;
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign WDT_IRQ = irq_r;
  assign IRQ_PRIO_HIGH = prio_r;
  assign WDT_RESET_REQ = rst_req_r;

endmodule : wdtc_top

// [design/wdtc_regs.svh]
/*
  Register map, field positions, reset values and timing figures of the
  watchdog timeout control block. Assumes an APB slave with byte addresses.
*/
`ifndef WDTC_REGS_SVH
`define WDTC_REGS_SVH

// byte offsets
`define WDTC_OFF_CTRL 8'h00
`define WDTC_OFF_IRQ_STAT 8'h04
`define WDTC_OFF_IRQ_MASK 8'h08

// watchdog_control fields
`define WDTC_SEL_HI 7
`define WDTC_SEL_LO 4
`define WDTC_IRSEL_BIT 3
`define WDTC_FLAG_BIT 2
`define WDTC_ARM_BIT 1
`define WDTC_UNLOCK_BIT 0
`define WDTC_CTRL_RESET 8'h10

// interrupt status / mask layout
`define WDTC_IRQ_TIMEOUT_BIT 0
`define WDTC_IRQ_STAT_RESET 1'h0
`define WDTC_IRQ_MASK_RESET 1'h0

// timeout select codes
`define WDTC_CODE_LAST_TIMED 4'h7
`define WDTC_CODE_IMMEDIATE 4'h8

// time base
`define WDTC_CLK_HZ 250000000
`define WDTC_BASE_HZ 32768
`define WDTC_BASE_TICKS 512
`define WDTC_CNT_W 17

`endif

// [design/wdtc_pkg.sv]
/*
  Types of the watchdog timeout control block.
  Assumes the constants of wdtc_regs.svh for field layout.
*/
package wdtc_pkg;

  typedef struct packed {
    logic [3:0] sel;
    logic irsel;
    logic flag;
    logic arm;
  } wdtc_ctrl_t;

  typedef enum logic {
    WDTC_LOCKED,
    WDTC_OPEN
  } wdtc_lock_t;

endpackage : wdtc_pkg

// [tb/wdtc_props.sv]
/*
  Port checks of wdtc_top, bound into it.
  Assumes APB answers with no wait state.
*/
`timescale 1ns/1ps
module wdtc_props (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // system
  input wire logic WDT_IRQ,
  input wire logic IRQ_PRIO_HIGH,
  input wire logic WDT_RESET_REQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // slot as seen on the bus: any completed transfer closes it
  logic slot_r;
  logic slot_nxt;
  logic ctl_wr;
  assign ctl_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00;
  always_comb begin
    slot_nxt = (PSEL && PENABLE && PREADY) ? (!slot_r && ctl_wr && PWDATA[0]) : slot_r;
  end
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      slot_r <= 1'b0;
    end else begin
      slot_r <= slot_nxt;
    end
  end
  property p_prio; IRQ_PRIO_HIGH; endproperty
  a_prio: assert property (p_prio) else $error("priority low");
  property p_pulse; WDT_RESET_REQ |=> !WDT_RESET_REQ; endproperty
  a_pulse: assert property (p_pulse) else $error("reset req held");
  property p_ready; PSEL && !PENABLE |=> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_err; PSLVERR |-> PREADY && PRDATA == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error reply");
  property p_map; PREADY && PADDR == 8'h0C |-> PSLVERR; endproperty
  a_map: assert property (p_map) else $error("unmapped accepted");
  property p_stat; PREADY && !PWRITE && PADDR == 8'h04 |-> PRDATA[31:1] == 31'h0; endproperty
  a_stat: assert property (p_stat) else $error("status upper bits");
  // only a bus write may take a raised interrupt down
  property p_hold; WDT_IRQ && !(PSEL && PWRITE) && !$past(PSEL && PWRITE) |=> WDT_IRQ;
  endproperty
  a_hold: assert property (p_hold) else $error("interrupt dropped");
  property p_imm; ctl_wr && slot_r && PWDATA[7:4] == 4'h8 && PWDATA[1] |-> ##[1:4] WDT_RESET_REQ;
  endproperty
  a_imm: assert property (p_imm) else $error("no immediate reset");
  c_irq: cover property (WDT_IRQ);
  c_rst: cover property (WDT_RESET_REQ);
  c_err: cover property (PSLVERR);
endmodule : wdtc_props
bind wdtc_top wdtc_props u_props (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .WDT_IRQ(WDT_IRQ), .IRQ_PRIO_HIGH(IRQ_PRIO_HIGH),
  .WDT_RESET_REQ(WDT_RESET_REQ));

// [tb/watchdog_timeout_control_bench.sv]
/*
  Self-checking bench of wdtc_top over APB.
  Assumes DIV_CYCLES 4 and BASE_TICKS 2, so code 0 lasts 8 clocks.
*/
`timescale 1ns/1ps
`include "wdtc_regs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %0t: got %0h exp %0h", $time, g, e); end end
module watchdog_timeout_control_bench;
  localparam int P = 8;
  logic clk = 0;
  logic rst_b = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic alarm = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic pready, pslverr, irq, prio, rreq, err;
  int n_fail = 0;
  int check_count = 0;
  int n, c0;
  int n_rreq = 0;
  // every reset request pulse is counted, not just those at sample points
  always @(posedge clk) begin
    if (rreq === 1'b1) begin
      n_rreq++;
    end
  end
  wdtc_top #(.DIV_CYCLES(4), .BASE_TICKS(2)) DUT (.CLK(clk), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SUPPLY_ALARM(alarm), .WDT_IRQ(irq),
    .IRQ_PRIO_HIGH(prio), .WDT_RESET_REQ(rreq));
  always #2 clk = ~clk;
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdata, e)
  endtask : rc
  // unlock, then the control write itself
  task cw(input logic [7:0] d);
    apb(1'b1, `WDTC_OFF_CTRL, 32'h01);
    apb(1'b1, `WDTC_OFF_CTRL, {24'h0, d});
  endtask : cw
  // bounded wait on interrupt or reset request, cycles waited in n
  task wt(input bit on_irq, input int lim);
    n = 0;
    while (((on_irq ? irq : rreq) !== 1'b1) && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wt
  task t_lock;
    rc(`WDTC_OFF_CTRL, 32'h10);
    rc(`WDTC_OFF_IRQ_STAT, 32'h0);
    rc(`WDTC_OFF_IRQ_MASK, 32'h0);
    `CHK(prio, 1'b1)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, `WDTC_OFF_CTRL, 32'h72);
    rc(`WDTC_OFF_CTRL, 32'h10);
    apb(1'b1, `WDTC_OFF_CTRL, 32'h01);
    rc(`WDTC_OFF_CTRL, 32'h11);
    apb(1'b1, `WDTC_OFF_CTRL, 32'h72);
    rc(`WDTC_OFF_CTRL, 32'h10);
    $display("t_lock done");
  endtask : t_lock
  task t_periods;
    for (int k = 0; k < 8; k++) begin
      cw({k[3:0], 4'h2});
      wt(1'b0, 2000);
      `CHK(n >= (P << k) - 1 && n <= (P << k) + 3, 1'b1)
      rc(`WDTC_OFF_CTRL, {24'h0, k[3:0], 4'h4});
      cw({k[3:0], 4'h0});
      rc(`WDTC_OFF_CTRL, {24'h0, k[3:0], 4'h0});
    end
    cw(8'h82);
    wt(1'b0, 10);
    `CHK(n <= 4, 1'b1)
    $display("t_periods done");
  endtask : t_periods
  task t_refresh;
    cw(8'h22);
    c0 = n_rreq;
    repeat (4) begin
      repeat (12) @(posedge clk);
      cw(8'h22);
    end
    `CHK(n_rreq - c0, 0)
    wt(1'b0, 100);
    `CHK(rreq, 1'b1)
    $display("t_refresh done");
  endtask : t_refresh
  task t_irq;
    apb(1'b1, `WDTC_OFF_IRQ_MASK, 32'h1);
    cw(8'h2A);
    wt(1'b1, 100);
    `CHK(irq, 1'b1)
    `CHK(rreq, 1'b0)
    apb(1'b1, `WDTC_OFF_IRQ_STAT, 32'h1);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    wt(1'b1, 100);
    `CHK(irq, 1'b1)
    rc(`WDTC_OFF_CTRL, 32'h2E);
    apb(1'b1, `WDTC_OFF_IRQ_MASK, 32'h0);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    rc(`WDTC_OFF_IRQ_STAT, 32'h1);
    alarm <= 1'b1;
    @(posedge clk);
    alarm <= 1'b0;
    rc(`WDTC_OFF_CTRL, 32'h2C);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rc(`WDTC_OFF_CTRL, 32'h10);
    $display("t_irq done");
  endtask : t_irq
  task summarize;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  // limit well above the sum of all periods
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_lock;
    t_periods;
    t_refresh;
    t_irq;
    summarize;
  end
endmodule : watchdog_timeout_control_bench
